// ===== cal_map.svh
// Register indices, field positions, reset values and timing counts of the
// calibration control and status bank.
// Included by every design file that decodes or builds these registers.
`ifndef CAL_MAP_SVH
`define CAL_MAP_SVH

// Register indices; the byte address on the bus is four times the index.
`define IDX_AVG          8'h68
`define IDX_PROGRESS     8'h6a
`define IDX_ROUTING      8'h6b
`define IDX_SWTRIG       8'h6c
`define IDX_CTRL         8'h70

// Reset values.
`define RST_AVG          8'h61
`define RST_PROGRESS     8'h00
`define RST_ROUTING      8'h00
`define RST_SWTRIG       8'h01
`define RST_CTRL         8'h03

// Averaging register fields.
`define OFS_AVG_MSB      6
`define OFS_AVG_LSB      4
`define LIN_AVG_MSB      2
`define LIN_AVG_LSB      0

// Pin routing and software trigger fields.
`define SEL_MSB          2
`define SEL_LSB          1
`define HWSEL_BIT        0
`define SWTRIG_BIT       0

// Control register fields.
`define CTRL_RUN_BIT     0
`define CTRL_FG_BIT      1
`define CTRL_BG_BIT      2
`define CTRL_LPTRIG_BIT  3

// Sequencer timing in clock cycles.
`define FG_BASE_CYCLES   13'h0010
`define BG_PHASE_CYCLES  13'h0020

`endif

// ===== cal_pkg.sv
// Types shared by the calibration register bank and its sequencer.
// Needs nothing from its surroundings.
package cal_pkg;

  typedef enum logic [2:0] {
    SEQ_HELD,
    SEQ_FOREGROUND,
    SEQ_FG_IDLE,
    SEQ_BACKGROUND,
    SEQ_HALTED
  } seq_state_t;

  typedef enum logic [1:0] {
    SEL_FG_FINISHED,
    SEL_BG_HALTED,
    SEL_ALARM,
    SEL_LOW
  } pin_sel_t;

endpackage

// ===== calib_if.sv
// Bundle between the register bank and the calibration sequencer.
// The bank drives the settings, the sequencer drives the status.
`timescale 1ns/10ps
interface calib_if;
  logic       runEnable;
  logic       fgEnable;
  logic       bgEnable;
  logic       trigger;
  logic [2:0] offsetAvgDepth;
  logic [2:0] linearityAvgDepth;
  logic       fgFinished;
  logic       bgHalted;
  logic [2:0] statusCode;

  modport bank (
    output runEnable,
    output fgEnable,
    output bgEnable,
    output trigger,
    output offsetAvgDepth,
    output linearityAvgDepth,
    input  fgFinished,
    input  bgHalted,
    input  statusCode
  );

  modport engine (
    input  runEnable,
    input  fgEnable,
    input  bgEnable,
    input  trigger,
    input  offsetAvgDepth,
    input  linearityAvgDepth,
    output fgFinished,
    output bgHalted,
    output statusCode
  );
endinterface

// ===== calib_sequencer.sv
// Calibration sequencer: foreground pass, then background phases.
// Assumes synchronous settings and a reset already released on sys_clk.
`timescale 1ns/10ps
`include "cal_map.svh"
module calib_sequencer (
  input wire logic sys_clk,
  input wire logic rstSyncB,
  calib_if.engine  cal
);

  cal_pkg::seq_state_t state;
  cal_pkg::seq_state_t next_state;
  logic [12:0]         count;
  logic [12:0]         next_count;
  logic                fgLast;
  logic                phaseLast;

  // Foreground length grows with both averaging depths.
  function automatic logic [12:0] fgLength(input logic [2:0] lin,
                                           input logic [2:0] ofs);
    fgLength = (`FG_BASE_CYCLES << lin) + (`FG_BASE_CYCLES << ofs);
  endfunction

  function automatic logic [2:0] codeOf(input cal_pkg::seq_state_t s);
    codeOf = 3'(s);
  endfunction

  assign fgLast    = count == fgLength(cal.linearityAvgDepth,
                                       cal.offsetAvgDepth) - 13'h0001;
  assign phaseLast = count == `BG_PHASE_CYCLES - 13'h0001;

  always_comb begin
    next_state = state;
    case (state)
      cal_pkg::SEQ_HELD: begin
        if (cal.runEnable) begin
          next_state = cal.fgEnable ? cal_pkg::SEQ_FOREGROUND
                                    : cal_pkg::SEQ_FG_IDLE;
        end
      end
      cal_pkg::SEQ_FOREGROUND: begin
        if (fgLast) begin
          next_state = cal.bgEnable ? cal_pkg::SEQ_BACKGROUND
                                    : cal_pkg::SEQ_FG_IDLE;
        end
      end
      cal_pkg::SEQ_FG_IDLE: begin
        if (cal.bgEnable) begin // R17
          next_state = cal_pkg::SEQ_BACKGROUND;
        end
      end
      cal_pkg::SEQ_BACKGROUND: begin
        if (!cal.bgEnable) begin // R17
          next_state = cal_pkg::SEQ_FG_IDLE;
        end else if (phaseLast && !cal.trigger) begin // R4
          next_state = cal_pkg::SEQ_HALTED;
        end
      end
      cal_pkg::SEQ_HALTED: begin
        if (!cal.bgEnable) begin
          next_state = cal_pkg::SEQ_FG_IDLE;
        end else if (cal.trigger) begin // R5
          next_state = cal_pkg::SEQ_BACKGROUND;
        end
      end
      default: begin
        next_state = cal_pkg::SEQ_HELD;
      end
    endcase
    if (!cal.runEnable) begin // R16
      next_state = cal_pkg::SEQ_HELD;
    end
    // Only a background phase wraps the counter; a long foreground must not.
    next_count = (next_state != state
                  || (phaseLast && state == cal_pkg::SEQ_BACKGROUND))
                 ? 13'h0000 : count + 13'h0001;
  end

  always_ff @(posedge sys_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      state          <= cal_pkg::SEQ_HELD;
      count          <= 13'h0000;
      cal.fgFinished <= 1'b0;
      cal.bgHalted   <= 1'b0;
      cal.statusCode <= 3'h0;
    end else begin
      state          <= next_state;
      count          <= next_count;
      cal.fgFinished <= next_state inside {cal_pkg::SEQ_FG_IDLE,
          cal_pkg::SEQ_BACKGROUND, cal_pkg::SEQ_HALTED}; // R7
      cal.bgHalted   <= next_state == cal_pkg::SEQ_HALTED
          || (next_state == cal_pkg::SEQ_FG_IDLE && !cal.bgEnable); // R4 R6
      cal.statusCode <= codeOf(next_state); // R8
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstSyncB);

  a_skip_sets_done: assert property ( // R7
    state == cal_pkg::SEQ_HELD && cal.runEnable && !cal.fgEnable
    |=> cal.fgFinished && cal.bgHalted == !$past(cal.bgEnable))
    else $error("skipped foreground did not set the finished flag");

  a_held_clears: assert property ( // R16
    !cal.runEnable |=> !cal.fgFinished && !cal.bgHalted
    && state == cal_pkg::SEQ_HELD)
    else $error("calibration not held while run enable is low");

  a_no_bg_halted: assert property ( // R6
    cal.fgFinished && !cal.bgEnable && cal.runEnable |=> cal.bgHalted)
    else $error("halted flag missing with background disabled");

  a_resume_clears: assert property ( // R5
    state == cal_pkg::SEQ_HALTED && cal.trigger && cal.bgEnable
    && cal.runEnable |=> !cal.bgHalted)
    else $error("halted flag stayed set after resume");

  a_stop_at_phase: assert property ( // R4
    $rose(cal.bgHalted) && cal.bgEnable && $past(cal.bgEnable)
    |-> $past(phaseLast) && !$past(cal.trigger))
    else $error("background stopped outside a phase end");

  c_halted: cover property (state == cal_pkg::SEQ_HALTED
    ##[1:200] state == cal_pkg::SEQ_BACKGROUND);
  c_fg_run: cover property (state == cal_pkg::SEQ_FOREGROUND
    ##1 state == cal_pkg::SEQ_BACKGROUND);

endmodule

// ===== calibration_trigger_status_regs.sv
// Calibration control and status register bank behind an Avalon-MM slave.
// Assumes one 50 MHz clock; the trigger pin is asynchronous to it.
//
// How it works
// R1: Averaging bits 6:4 set offset averaging depth, reset value six.
// R2: Averaging bits 2:0 set linearity averaging depth, reset value one.
// R3: Software writes reset values back into reserved read-write bits.
// R4: Status bit 1 reads one once background stops at requested phase.
// R5: Status bit 1 clears as soon as calibration resumes.
// R6: Background disabled: bit 1 sets once foreground completes or skips.
// R7: Status bit 0 reads high once foreground completes or is skipped.
// R8: Status register is read-only; code in bits 4:2, bits 7:5 reserved.
// R9: Routing bits 2:1 pick finished, halted, alarm or low for status pin.
// R10: Hardware select zero takes the software bit, ignores trigger pin.
// R11: Hardware select one takes the trigger pin, ignores software bit.
// R12: Software trigger bit acts exactly like the trigger pin level.
// R13: Software trigger register resets to one, trigger held high.
// R14: Unneeded trigger: software leaves select zero and software bit one.
// R15: Pin routing register resets to all zeros.
// R16: Clearing run enable holds calibration in reset; setting reruns it.
// R17: Background runs only while its enable is set; enable resets zero.
// R18: Triggered low-power mode wakes the offline core while trigger low.
// R19: Trigger pin passes two flip-flops before use.
// R20: Writes to the status register change no flag and no code.
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/10ps
`include "cal_map.svh"
module calibration_trigger_status_regs (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output      logic [31:0] avs_readdata,
  output      logic        avs_waitrequest,
  input  wire logic        triggerInputPin,
  input  wire logic        alarmFlag,
  output      logic        statusOutputPin,
  output      logic        coreWake
);

  logic                rstMeta;
  logic                rstSyncB;
  logic                trigMeta;
  logic                trigSync;
  logic [7:0]          avgReg;
  logic [7:0]          routingReg;
  logic [7:0]          swTrigReg;
  logic [7:0]          ctrlReg;
  wire  [7:0]          regIndex;
  wire                 busReq;
  wire                 wrAccept;
  wire                 hitAvg;
  wire                 hitProgress;
  wire                 hitRouting;
  wire                 hitSwTrig;
  wire                 hitCtrl;
  wire  [7:0]          progressByte;
  wire  [7:0]          readByte;
  wire  [31:0]         readMux;
  wire                 selTrig;
  wire                 lowPowerTrig;
  wire                 pinSource;
  cal_pkg::pin_sel_t   pinSel;

  calib_if cal ();

  // Reset is released through two flip-flops.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta  <= 1'b0;
      rstSyncB <= 1'b0;
    end else begin
      rstMeta  <= 1'b1;
      rstSyncB <= rstMeta;
    end
  end

  always_ff @(posedge sys_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      trigMeta <= 1'b1;
      trigSync <= 1'b1;
    end else begin
      trigMeta <= triggerInputPin; // R19
      trigSync <= trigMeta; // R19
    end
  end

  // Address decode; printed offsets are indices, so drop the byte bits.
  assign regIndex    = avs_address[9:2];
  assign busReq      = avs_read || avs_write;
  assign wrAccept    = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign hitAvg      = regIndex == `IDX_AVG;
  assign hitProgress = regIndex == `IDX_PROGRESS; // R20
  assign hitRouting  = regIndex == `IDX_ROUTING;
  assign hitSwTrig   = regIndex == `IDX_SWTRIG;
  assign hitCtrl     = regIndex == `IDX_CTRL;

  assign progressByte = {3'b000, cal.statusCode, cal.bgHalted,
                         cal.fgFinished}; // R8

  // Unmapped indices read as zero and ignore writes.
  assign readByte = hitAvg      ? avgReg       :
                    hitProgress ? progressByte :
                    hitRouting  ? routingReg   :
                    hitSwTrig   ? swTrigReg    :
                    hitCtrl     ? ctrlReg      : 8'h00;
  assign readMux  = {24'h00_0000, readByte};

  // Every request is answered one cycle after it is first seen.
  always_ff @(posedge sys_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= !(busReq && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= readMux;
      end
    end
  end

  // Reserved read-write bits are stored as written; software restores them.
  always_ff @(posedge sys_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      avgReg <= `RST_AVG; // R1 R2
    end else if (wrAccept && hitAvg) begin
      avgReg <= avs_writedata[7:0]; // R3
    end
  end

  always_ff @(posedge sys_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      routingReg <= `RST_ROUTING; // R15
    end else if (wrAccept && hitRouting) begin
      routingReg <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      swTrigReg <= `RST_SWTRIG; // R13
    end else if (wrAccept && hitSwTrig) begin
      swTrigReg <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      ctrlReg <= `RST_CTRL; // R17
    end else if (wrAccept && hitCtrl) begin
      ctrlReg <= avs_writedata[7:0];
    end
  end

  // Trigger source: pin when hardware select is set, else software bit.
  assign selTrig = routingReg[`HWSEL_BIT] ? trigSync // R11
                                          : swTrigReg[`SWTRIG_BIT]; // R10 R12

  assign cal.runEnable         = ctrlReg[`CTRL_RUN_BIT]; // R16
  assign cal.fgEnable          = ctrlReg[`CTRL_FG_BIT];
  assign cal.bgEnable          = ctrlReg[`CTRL_BG_BIT]; // R17
  assign cal.trigger           = selTrig;
  assign cal.offsetAvgDepth    = avgReg[`OFS_AVG_MSB:`OFS_AVG_LSB]; // R1
  assign cal.linearityAvgDepth = avgReg[`LIN_AVG_MSB:`LIN_AVG_LSB]; // R2

  calib_sequencer sequencer (
    .sys_clk  (sys_clk),
    .rstSyncB (rstSyncB),
    .cal      (cal)
  );

  assign pinSel       = cal_pkg::pin_sel_t'(routingReg[`SEL_MSB:`SEL_LSB]);
  assign pinSource    = (pinSel == cal_pkg::SEL_FG_FINISHED) ? cal.fgFinished :
                        (pinSel == cal_pkg::SEL_BG_HALTED)   ? cal.bgHalted   :
                        (pinSel == cal_pkg::SEL_ALARM)       ? alarmFlag
                                                             : 1'b0; // R9
  assign lowPowerTrig = ctrlReg[`CTRL_LPTRIG_BIT];

  // Outside triggered low-power mode the core is left awake.
  always_ff @(posedge sys_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      statusOutputPin <= 1'b0;
      coreWake        <= 1'b1;
    end else begin
      statusOutputPin <= pinSource; // R9
      coreWake        <= lowPowerTrig ? !selTrig : 1'b1; // R18
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstSyncB);

  a_reset_values: assert property ( // R1 R2 R13 R15
    !$past(rstSyncB) |-> avgReg == `RST_AVG && swTrigReg == `RST_SWTRIG
    && routingReg == `RST_ROUTING && ctrlReg == `RST_CTRL)
    else $error("register reset values wrong");

  a_sw_trig_used: assert property ( // R10
    !routingReg[`HWSEL_BIT] && $stable(swTrigReg) [*2]
    |-> cal.trigger == swTrigReg[`SWTRIG_BIT])
    else $error("software trigger not used with select zero");

  a_pin_trig_used: assert property ( // R11
    routingReg[`HWSEL_BIT] && swTrigReg[`SWTRIG_BIT] != trigSync
    |-> cal.trigger == trigSync)
    else $error("trigger pin not used with select one");

  a_pin_sync_delay: assert property ( // R19
    routingReg[`HWSEL_BIT] && $stable(routingReg)
    |-> cal.trigger == $past(triggerInputPin, 2))
    else $error("trigger pin not delayed by two flip-flops");

  a_pin_low_sel: assert property ( // R9
    pinSel == cal_pkg::SEL_LOW |=> !statusOutputPin)
    else $error("status pin not low for selector three");

  a_pin_follows: assert property ( // R9
    pinSel == cal_pkg::SEL_BG_HALTED |=> statusOutputPin == $past(cal.bgHalted))
    else $error("status pin does not follow the halted flag");

  a_status_ro: assert property ( // R20
    wrAccept && hitProgress |=> $stable(avgReg) && $stable(routingReg)
    && $stable(swTrigReg) && $stable(ctrlReg))
    else $error("status write disturbed a register");

  a_wake_trig: assert property ( // R18
    lowPowerTrig && !selTrig |=> coreWake)
    else $error("core not woken while trigger low");

  a_bus_answer: assert property (
    busReq && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not given after one cycle");

  a_wr_avg_lands: assert property ( // R1 R2
    wrAccept && hitAvg |=> avgReg == $past(avs_writedata[7:0]))
    else $error("averaging write did not land");

  a_wr_route_lands: assert property ( // R9
    wrAccept && hitRouting |=> routingReg == $past(avs_writedata[7:0]))
    else $error("routing write did not land");

  a_wr_swtrig_lands: assert property ( // R12
    wrAccept && hitSwTrig |=> swTrigReg == $past(avs_writedata[7:0]))
    else $error("software trigger write did not land");

  a_wr_ctrl_lands: assert property ( // R16
    wrAccept && hitCtrl |=> ctrlReg == $past(avs_writedata[7:0]))
    else $error("control write did not land");

  a_byte_off_ignored: assert property (
    avs_write && !avs_waitrequest && !avs_byteenable[0]
    |=> $stable(avgReg) && $stable(routingReg)
    && $stable(swTrigReg) && $stable(ctrlReg))
    else $error("write without byte enable changed a register");

  a_read_data_taken: assert property (
    avs_read && avs_waitrequest |=> avs_readdata == $past(readMux))
    else $error("read data not loaded from the addressed register");

  a_read_high_zero: assert property ( // R8
    !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");

  a_pin_follows_fg: assert property ( // R9
    pinSel == cal_pkg::SEL_FG_FINISHED
    |=> statusOutputPin == $past(cal.fgFinished))
    else $error("status pin does not follow the finished flag");

  a_pin_follows_alarm: assert property ( // R9
    pinSel == cal_pkg::SEL_ALARM |=> statusOutputPin == $past(alarmFlag))
    else $error("status pin does not follow the alarm flag");

  a_wake_idle_mode: assert property ( // R18
    !lowPowerTrig |=> coreWake)
    else $error("core not awake outside triggered low-power mode");

  a_sleep_trig_high: assert property ( // R18
    lowPowerTrig && selTrig |=> !coreWake)
    else $error("core awake while trigger high");

  c_bus_write: cover property (wrAccept && hitRouting);
  c_hw_trigger: cover property (routingReg[`HWSEL_BIT] && $fell(cal.trigger));
  c_alarm_pin: cover property (pinSel == cal_pkg::SEL_ALARM && alarmFlag
    ##1 statusOutputPin);

endmodule

// ===== ext_trigger_ctrl.sv
// Model of the external controller that drives the trigger pin and
// watches the status pin. Assumes the bench commands the level on sys_clk.
`timescale 1ns/10ps
module ext_trigger_ctrl (
  input  wire logic sys_clk,
  input  wire logic wantLevel,
  input  wire logic slowMode,
  output      logic triggerInputPin,
  input  wire logic statusOutputPin,
  output      logic seenStatus
);
  logic [2:0] lag;

  initial begin
    triggerInputPin = 1'b1;
    seenStatus = 1'b0;
    lag = 3'h7;
  end

  // Slow mode lets a new level reach the pin three cycles late.
  always @(posedge sys_clk) begin
    lag <= {lag[1:0], wantLevel};
    triggerInputPin <= slowMode ? lag[2] : wantLevel;
    seenStatus <= statusOutputPin;
  end
endmodule

// ===== calibration_trigger_status_regs_tb.sv
// Self-checking bench for the calibration control and status bank.
// Assumes the bank answers each bus request after one wait cycle.
`timescale 1ns/10ps
module calibration_trigger_status_regs_tb;
  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] data;
    logic       be;
    logic [7:0] want;
  } row_t;

  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [9:0]  avs_address = 10'h000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        triggerInputPin;
  logic        alarmFlag = 1'b0;
  logic        statusOutputPin;
  logic        coreWake;
  logic        wantLevel = 1'b1;
  logic        slowMode = 1'b0;
  logic        seenStatus;
  logic [31:0] rdat;
  int          fails = 0;
  int          check_count = 0;
  row_t        rows [6] = '{
    '{8'h68, 8'h35, 1'b1, 8'h35}, '{8'h6b, 8'h06, 1'b0, 8'h00},
    '{8'h6b, 8'h06, 1'b1, 8'h06}, '{8'h6c, 8'h00, 1'b1, 8'h00},
    '{8'h40, 8'haa, 1'b1, 8'h00}, '{8'h70, 8'h0b, 1'b1, 8'h0b}};

  always #10 sys_clk = ~sys_clk;

  calibration_trigger_status_regs DUT (
    .sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .triggerInputPin(triggerInputPin), .alarmFlag(alarmFlag),
    .statusOutputPin(statusOutputPin), .coreWake(coreWake));

  ext_trigger_ctrl partner (
    .sys_clk(sys_clk), .wantLevel(wantLevel), .slowMode(slowMode),
    .triggerInputPin(triggerInputPin), .statusOutputPin(statusOutputPin),
    .seenStatus(seenStatus));

  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t reg got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_pin(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t pin got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // The request stands until the edge that samples waitrequest low.
  task automatic bus_xfer(input logic [7:0] idx, input logic wr,
      input logic [7:0] data, input logic be, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h00_0000, data};
    avs_byteenable <= {3'h0, be};
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 100) begin
      fails++;
      $display("[FAIL] t=%0t bus got=%h exp=%h", $time, n, 0);
      give_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] data);
    logic [31:0] dummy;
    bus_xfer(idx, 1'b1, data, 1'b1, dummy);
  endtask

  task automatic rd_cmp(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] r;
    bus_xfer(idx, 1'b0, 8'h00, 1'b1, r);
    cmp_word(r, {24'h00_0000, exp});
  endtask

  task automatic route_check(input logic halted);
    logic want;
    for (int s = 0; s < 4; s++) begin
      for (int a = 0; a < 2; a++) begin
        want = (s == 0) ? 1'b1 : (s == 1) ? halted : (s == 2) ? a[0] : 1'b0;
        wr(8'h6b, {5'h00, s[1:0], 1'b0});
        alarmFlag <= a[0];
        ticks(4);
        cmp_pin(seenStatus, want);
      end
    end
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    give_verdict();
  end

  initial begin
    ticks(4);
    rst_b <= 1'b1;
    ticks(3);
    for (int i = 0; i < 6; i++) begin
      bus_xfer(rows[i].idx, 1'b1, rows[i].data, rows[i].be, rdat);
      rd_cmp(rows[i].idx, rows[i].want);
    end
    $display("Done: register table");
    rst_b <= 1'b0;
    ticks(2);
    cmp_pin(statusOutputPin, 1'b0);
    cmp_pin(coreWake, 1'b1);
    rst_b <= 1'b1;
    ticks(3);
    rd_cmp(8'h68, 8'h61);
    rd_cmp(8'h6b, 8'h00);
    rd_cmp(8'h6c, 8'h01);
    bus_xfer(8'h6a, 1'b0, 8'h00, 1'b1, rdat);
    cmp_word(rdat & 32'hffff_ffe0, 32'h0000_0000);
    $display("Done: reset values");
    // Reserved bits 7 and 3 keep their reset value of zero.
    wr(8'h68, 8'h00);
    wr(8'h70, 8'h00);
    rd_cmp(8'h6a, 8'h00);
    wr(8'h70, 8'h03);
    rd_cmp(8'h6a, 8'h04);
    ticks(60);
    rd_cmp(8'h6a, 8'h0b);
    cmp_pin(seenStatus, 1'b1);
    wr(8'h70, 8'h00);
    wr(8'h70, 8'h01);
    ticks(10);
    rd_cmp(8'h6a, 8'h0b);
    wr(8'h70, 8'h00);
    wr(8'h70, 8'h05);
    ticks(10);
    rd_cmp(8'h6a, 8'h0d);
    route_check(1'b0);
    $display("Done: sequence and routing");
    wr(8'h6b, 8'h00);
    wantLevel <= 1'b0;
    ticks(80);
    rd_cmp(8'h6a, 8'h0d);
    wr(8'h6c, 8'h00);
    ticks(80);
    rd_cmp(8'h6a, 8'h13);
    route_check(1'b1);
    wr(8'h6a, 8'hff);
    rd_cmp(8'h6a, 8'h13);
    wr(8'h6c, 8'h01);
    rd_cmp(8'h6a, 8'h0d);
    wr(8'h6b, 8'h01);
    ticks(80);
    rd_cmp(8'h6a, 8'h13);
    wantLevel <= 1'b1;
    slowMode <= 1'b1;
    ticks(10);
    rd_cmp(8'h6a, 8'h0d);
    wr(8'h70, 8'h0d);
    ticks(4);
    cmp_pin(coreWake, 1'b0);
    wantLevel <= 1'b0;
    slowMode <= 1'b0;
    ticks(2);
    cmp_pin(coreWake, 1'b0);
    ticks(6);
    cmp_pin(coreWake, 1'b1);
    wr(8'h6b, 8'h00);
    $display("Done: trigger source");
    give_verdict();
  end
endmodule
